// File: rtl/ier_pkg.sv
// Constants, types and frame layout for the interrupt-enable readback block
package ier_pkg;

    // Serial frame
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    localparam logic [1:0] VIEW_ADDR = 2'h1;
    localparam logic VIEW_SEL_ENABLE = 1'h0;
    localparam logic REPLY_NO_WRITE = 1'h0;

    // Enable bit positions within the 12-bit enable field
    localparam int EN_W = 12;
    localparam int EN_WDT = 11;
    localparam int EN_TEMP = 10;
    localparam int EN_GND = 9;
    localparam int EN_CCF = 8;
    localparam int EN_BAT = 7;
    localparam int EN_SUP = 6;
    localparam int EN_CANF = 5;
    localparam int EN_LINF = 4;
    localparam int EN_WAKE = 3;
    localparam int EN_RSVD = 2;
    localparam int EN_CANW = 1;
    localparam int EN_LINW = 0;

    // Values after reset
    localparam logic [11:0] ENABLE_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Operating mode reported by the mode controller
    typedef enum logic [2:0] {
        IER_MODE_STARTUP = 3'h0,
        IER_MODE_RESTART = 3'h1,
        IER_MODE_STANDBY = 3'h3,
        IER_MODE_NORMAL = 3'h2,
        IER_MODE_FLASH = 3'h6,
        IER_MODE_SLEEP = 3'h7
    } ier_mode_t;

    // Frame handling on the system clock
    typedef enum logic [1:0] {
        IER_IDLE = 2'h0,
        IER_ACTIVE = 2'h1,
        IER_CAPTURE = 2'h3,
        IER_APPLY = 2'h2
    } ier_frame_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic view_sel;
        logic no_write;
        logic [11:0] enables;
    } ier_frame_t;

    // One-cycle pulses from the event detectors
    typedef struct packed {
        logic wdt_overflow;
        logic temp_cross;
        logic gnd_cross;
        logic supply_short;
        logic can_fail_change;
        logic lin_fail_change;
        logic can_wake;
        logic lin_wake;
    } ier_event_t;

endpackage

// File: rtl/ier_sync.sv
// Two-stage level synchroniser into the system clock domain
`timescale 1ns/1ps
module ier_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] stage1;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

// File: rtl/ier_spi_link.sv
// Serial shifter on the link clock: bit count, receive word, reply bit select
`timescale 1ns/1ps
module ier_spi_link (
    // Link clock and hold-off from the system domain
    input wire logic sclk_i,
    input wire logic run_n_i,
    // Serial pins
    input wire logic mosi_i,
    output logic miso_o,
    // Reply word, static while a frame runs
    input wire logic [15:0] reply_i,
    // Frame contents, static once the link clock stops
    output logic [15:0] rx_word_o,
    output logic [4:0] bit_count_o
);

    // Held in reset by the system side between frames, so no link edge
    // is needed after a frame to clear the count
    always_ff @(posedge sclk_i or posedge run_n_i)
    begin
        if (run_n_i)
        begin
            rx_word_o <= ier_pkg::WORD_RESET;
            bit_count_o <= '0;
        end
        else
        begin
            rx_word_o <= {rx_word_o[14:0], mosi_i};
            if (bit_count_o != ier_pkg::CNT_MAX)
            begin
                bit_count_o <= bit_count_o + 5'h01;
            end
        end
    end

    // Reply leaves MSB first; the bit after each edge is ready before the next
    always_comb
    begin
        if (bit_count_o < ier_pkg::FRAME_LEN)
        begin
            miso_o = reply_i[4'hf - bit_count_o[3:0]];
        end
        else
        begin
            miso_o = 1'b0;
        end
    end

endmodule

// File: rtl/ier_interrupt_enable_readback.sv
// Interrupt-enable register with serial readback and event routing
`timescale 1ns/1ps
module ier_interrupt_enable_readback (
    // System clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Serial link from the host
    input wire logic sclk_i,
    input wire logic csn_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Monitored pins
    input wire logic battery_sense_i,
    input wire logic local_wake_i,
    // Device state and detector pulses
    input wire ier_pkg::ier_mode_t mode_i,
    input wire ier_pkg::ier_event_t event_i,
    // Results
    output logic [11:0] enables_o,
    output logic [15:0] irq_cause_o,
    output logic reset_req_o,
    output logic frame_done_o
);

    ier_pkg::ier_frame_state_t state;
    ier_pkg::ier_frame_state_t next_state;
    ier_pkg::ier_frame_t rx_frame;
    ier_pkg::ier_frame_t reply;
    logic [15:0] rx_word;
    logic [15:0] captured;
    logic [4:0] bit_count;
    logic [4:0] captured_count;
    logic [2:0] pins_sync;
    logic csn_sync;
    logic sense_sync;
    logic wake_sync;
    logic sense_prev;
    logic wake_prev;
    logic sense_fall;
    logic wake_fall;
    logic link_run_n;
    logic frame_good;
    logic frame_bad;
    logic write_ok;
    logic [15:0] next_irq;
    logic next_reset;

    function automatic logic write_mode(input ier_pkg::ier_mode_t m);
        write_mode = (m == ier_pkg::IER_MODE_NORMAL) || (m == ier_pkg::IER_MODE_STANDBY);
    endfunction

    function automatic logic boot_mode(input ier_pkg::ier_mode_t m);
        boot_mode = (m == ier_pkg::IER_MODE_STARTUP) || (m == ier_pkg::IER_MODE_RESTART);
    endfunction

    // Chip select idles high, the monitored pins idle high
    ier_sync #(
        .W(3),
        .INIT(3'h7)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i({csn_n_i, battery_sense_i, local_wake_i}),
        .sync_o(pins_sync)
    );

    assign csn_sync = pins_sync[2];
    assign sense_sync = pins_sync[1];
    assign wake_sync = pins_sync[0];

    ier_spi_link u_link (
        .sclk_i(sclk_i),
        .run_n_i(link_run_n),
        .mosi_i(mosi_i),
        .miso_o(miso_o),
        .reply_i(reply),
        .rx_word_o(rx_word),
        .bit_count_o(bit_count)
    );

    // Frame sequencing: the link words are only read once the link clock
    // has stopped, which the synchronised chip select guarantees
    always_comb
    begin
        next_state = state;
        case (state)
            ier_pkg::IER_IDLE:
            begin
                if (!csn_sync)
                begin
                    next_state = ier_pkg::IER_ACTIVE;
                end
            end
            ier_pkg::IER_ACTIVE:
            begin
                if (csn_sync)
                begin
                    next_state = ier_pkg::IER_CAPTURE;
                end
            end
            ier_pkg::IER_CAPTURE:
            begin
                next_state = ier_pkg::IER_APPLY;
            end
            ier_pkg::IER_APPLY:
            begin
                next_state = ier_pkg::IER_IDLE;
            end
            default:
            begin
                next_state = ier_pkg::IER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ier_pkg::IER_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Link stays released through capture, or its words clear before they are taken
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            link_run_n <= 1'b1;
        end
        else
        begin
            link_run_n <= (next_state == ier_pkg::IER_IDLE) || (next_state == ier_pkg::IER_APPLY);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            miso_oe_o <= 1'b0;
        end
        else
        begin
            miso_oe_o <= !csn_sync;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            captured <= ier_pkg::WORD_RESET;
            captured_count <= '0;
        end
        else if (state == ier_pkg::IER_CAPTURE)
        begin
            captured <= rx_word;
            captured_count <= bit_count;
        end
    end

    // Reply is frozen during a frame, so a write shows the old settings
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reply <= {ier_pkg::VIEW_ADDR, ier_pkg::VIEW_SEL_ENABLE,
                      ier_pkg::REPLY_NO_WRITE, ier_pkg::ENABLE_RESET};
        end
        else if (state == ier_pkg::IER_IDLE)
        begin
            reply.addr <= ier_pkg::VIEW_ADDR;
            reply.view_sel <= ier_pkg::VIEW_SEL_ENABLE;
            reply.no_write <= ier_pkg::REPLY_NO_WRITE;
            reply.enables <= enables_o;
        end
    end

    assign rx_frame = captured;
    assign frame_good = (state == ier_pkg::IER_APPLY)
                        && (captured_count == ier_pkg::FRAME_LEN);
    assign frame_bad = (state == ier_pkg::IER_APPLY)
                       && (captured_count != ier_pkg::FRAME_LEN);
    assign write_ok = frame_good
                      && (rx_frame.addr == ier_pkg::VIEW_ADDR)
                      && (rx_frame.view_sel == ier_pkg::VIEW_SEL_ENABLE)
                      && !rx_frame.no_write
                      && write_mode(mode_i);

    // Overflow clear is applied after the write: fail-safe wins
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            enables_o <= ier_pkg::ENABLE_RESET;
        end
        else
        begin
            if (write_ok)
            begin
                enables_o <= rx_frame.enables;
            end
            if (event_i.wdt_overflow)
            begin
                enables_o[ier_pkg::EN_WDT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sense_prev <= 1'b1;
            wake_prev <= 1'b1;
        end
        else
        begin
            sense_prev <= sense_sync;
            wake_prev <= wake_sync;
        end
    end

    assign sense_fall = sense_prev && !sense_sync;
    assign wake_fall = wake_prev && !wake_sync;

    // Event routing: each event becomes an interrupt cause, a reset or nothing, by its enable and the mode
    always_comb
    begin
        next_irq = '0;
        next_reset = 1'b0;
        if (event_i.wdt_overflow)
        begin
            if (enables_o[ier_pkg::EN_WDT] && (mode_i == ier_pkg::IER_MODE_STANDBY))
            begin
                next_irq[ier_pkg::EN_WDT] = 1'b1;
            end
            else
            begin
                next_reset = 1'b1;
            end
        end
        next_irq[ier_pkg::EN_TEMP] = event_i.temp_cross && enables_o[ier_pkg::EN_TEMP];
        next_irq[ier_pkg::EN_GND] = event_i.gnd_cross && enables_o[ier_pkg::EN_GND];
        if (frame_bad && enables_o[ier_pkg::EN_CCF])
        begin
            if (boot_mode(mode_i))
            begin
                next_reset = 1'b1;
            end
            else
            begin
                next_irq[ier_pkg::EN_CCF] = 1'b1;
            end
        end
        next_irq[ier_pkg::EN_BAT] = sense_fall && enables_o[ier_pkg::EN_BAT];
        next_irq[ier_pkg::EN_SUP] = event_i.supply_short && enables_o[ier_pkg::EN_SUP];
        next_irq[ier_pkg::EN_CANF] = event_i.can_fail_change
                                     && enables_o[ier_pkg::EN_CANF];
        next_irq[ier_pkg::EN_LINF] = event_i.lin_fail_change
                                     && enables_o[ier_pkg::EN_LINF];
        if (wake_fall)
        begin
            if (enables_o[ier_pkg::EN_WAKE])
            begin
                next_irq[ier_pkg::EN_WAKE] = (mode_i == ier_pkg::IER_MODE_NORMAL)
                                             || (mode_i == ier_pkg::IER_MODE_FLASH)
                                             || (mode_i == ier_pkg::IER_MODE_STANDBY);
            end
            else if (mode_i == ier_pkg::IER_MODE_STANDBY)
            begin
                next_reset = 1'b1;
            end
        end
        if (event_i.can_wake)
        begin
            if (enables_o[ier_pkg::EN_CANW])
            begin
                next_irq[ier_pkg::EN_CANW] = 1'b1;
            end
            else
            begin
                next_reset = 1'b1;
            end
        end
        if (event_i.lin_wake)
        begin
            if (enables_o[ier_pkg::EN_LINW])
            begin
                next_irq[ier_pkg::EN_LINW] = 1'b1;
            end
            else
            begin
                next_reset = 1'b1;
            end
        end
    end

    // A bad frame with its enable clear reaches none of the above
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_cause_o <= '0;
            reset_req_o <= 1'b0;
            frame_done_o <= 1'b0;
        end
        else
        begin
            irq_cause_o <= next_irq;
            reset_req_o <= next_reset;
            frame_done_o <= frame_good;
        end
    end

endmodule

// File: verification/ier_host_model.sv
// Host model: SPI master framing words on its own link clock
`timescale 1ns/1ps
module ier_host_model (
    // Serial pins
    output logic sclk_o,
    output logic csn_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    initial
    begin
        sclk_o = 1'b0;
        csn_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Link clock runs only inside a frame, 64 ns period; n may differ from 16
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        logic [15:0] t;
        t = w & 16'hfffb;
        r = 'x;
        #1 csn_n_o = 1'b0;
        #400;
        for (int i = 0; i < n; i++)
        begin
            mosi_o = (i < 16) ? t[15 - i] : 1'b0;
            #32;
            if (i < 16)
                r[15 - i] = miso_oe_i ? miso_i : 1'bx;
            sclk_o = 1'b1;
            #32 sclk_o = 1'b0;
        end
        #32 csn_n_o = 1'b1;
        // Released line must not keep showing the last bit
        mosi_o = ~mosi_o;
    endtask
endmodule

// File: verification/ier_checker.sv
// Concurrent checks on the ports of the interrupt-enable readback block
`timescale 1ns/1ps
module ier_checker (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Observed ports
    input wire logic csn_n_i,
    input wire logic miso_oe_o,
    input wire ier_pkg::ier_mode_t mode_i,
    input wire ier_pkg::ier_event_t event_i,
    input wire logic [11:0] enables_o,
    input wire logic [15:0] irq_cause_o,
    input wire logic reset_req_o,
    input wire logic frame_done_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wdt_standby;
        event_i.wdt_overflow && enables_o[11] && mode_i == ier_pkg::IER_MODE_STANDBY;
    endsequence

    chk_oe_idle: assert property (csn_n_i [*4] |-> !miso_oe_o)
        else $error("miso driven outside a frame");
    chk_wdt_irq: assert property (s_wdt_standby |=> irq_cause_o[11] && !reset_req_o)
        else $error("watchdog overflow did not interrupt");
    chk_wdt_reset: assert property (event_i.wdt_overflow
        && !(enables_o[11] && mode_i == ier_pkg::IER_MODE_STANDBY)
        |=> reset_req_o && !irq_cause_o[11])
        else $error("watchdog overflow did not reset");
    chk_wdt_clear: assert property (event_i.wdt_overflow |=> !enables_o[11])
        else $error("watchdog enable not cleared");
    chk_temp_gate: assert property (event_i.temp_cross
        |=> irq_cause_o[10] == $past(enables_o[10]))
        else $error("temperature interrupt gating wrong");
    chk_supply_gate: assert property (event_i.supply_short
        |=> irq_cause_o[6] == $past(enables_o[6]))
        else $error("supply short interrupt gating wrong");
    chk_can_wake: assert property (event_i.can_wake
        |=> ($past(enables_o[1]) ? irq_cause_o[1] : reset_req_o))
        else $error("CAN wake routed wrongly");
    chk_lin_wake: assert property (event_i.lin_wake
        |=> ($past(enables_o[0]) ? irq_cause_o[0] : reset_req_o))
        else $error("LIN wake routed wrongly");
    chk_enable_hold: assert property (!$stable(enables_o)
        |-> frame_done_o || $past(event_i.wdt_overflow))
        else $error("enables changed without a frame");
endmodule

bind ier_interrupt_enable_readback ier_checker u_chk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .csn_n_i(csn_n_i),
    .miso_oe_o(miso_oe_o),
    .mode_i(mode_i),
    .event_i(event_i),
    .enables_o(enables_o),
    .irq_cause_o(irq_cause_o),
    .reset_req_o(reset_req_o),
    .frame_done_o(frame_done_o)
);

// File: verification/ier_interrupt_enable_readback_tb.sv
// Self-checking testbench for the interrupt-enable readback block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end
module ier_interrupt_enable_readback_tb;
    logic clock_i, rst_n_i, sclk, csn_n, mosi, miso, miso_oe, bat, wake;
    logic rreq, done, seen_clr, seen_rst;
    ier_pkg::ier_mode_t mode;
    ier_pkg::ier_event_t ev;
    logic [11:0] en;
    logic [15:0] irq, seen_irq, reply;
    int n_errors = 0;
    int checks_done = 0;
    int frames = 0;

    ier_host_model host (
        .sclk_o(sclk),
        .csn_n_o(csn_n),
        .mosi_o(mosi),
        .miso_i(miso),
        .miso_oe_i(miso_oe)
    );

    ier_interrupt_enable_readback uut (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .sclk_i(sclk),
        .csn_n_i(csn_n),
        .mosi_i(mosi),
        .miso_o(miso),
        .miso_oe_o(miso_oe),
        .battery_sense_i(bat),
        .local_wake_i(wake),
        .mode_i(mode),
        .event_i(ev),
        .enables_o(en),
        .irq_cause_o(irq),
        .reset_req_o(rreq),
        .frame_done_o(done)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // Outputs are one-cycle pulses, so gather them between checks
    always @(posedge clock_i)
    begin
        seen_irq <= (seen_clr || !rst_n_i) ? 16'h0000 : seen_irq | irq;
        seen_rst <= (seen_clr || !rst_n_i) ? 1'b0 : seen_rst | rreq;
        if (done === 1'b1)
            frames <= frames + 1;
    end

    task automatic clear_seen();
        seen_clr <= 1'b1;
        @(posedge clock_i);
        seen_clr <= 1'b0;
    endtask

    task automatic frame(input logic [15:0] w, input int n, input logic [11:0] e,
                         input logic [15:0] r);
        int f0;
        clear_seen();
        f0 = frames;
        host.xfer(w, n, reply);
        repeat (10) @(posedge clock_i);
        `CHK("frame count", f0 + (n == 16), frames)
        if (n == 16)
            `CHK("reply", r, reply)
        `CHK("enables", e, en)
    endtask

    task automatic ev_case(input ier_pkg::ier_event_t e, input logic b, input logic w,
                           input logic [15:0] xi, input logic xr);
        @(posedge clock_i);
        clear_seen();
        ev <= e;
        bat <= ~b;
        wake <= ~w;
        @(posedge clock_i);
        ev <= 8'h00;
        repeat (6) @(posedge clock_i);
        bat <= 1'b1;
        wake <= 1'b1;
        `CHK("irq cause", xi, seen_irq)
        `CHK("reset request", xr, seen_rst)
    endtask

    task automatic t_rw();
        frame(16'h4fff, 16, 12'hffb, 16'h4000);
        frame(16'h5000, 16, 12'hffb, 16'h4ffb);
        frame(16'h40e3, 16, 12'h0e3, 16'h4ffb);
        $display("read write test done");
    endtask

    task automatic t_refused();
        logic [15:0] ws [4];
        ier_pkg::ier_mode_t ms [4];
        ws = '{16'h8123, 16'h6123, 16'h0123, 16'hc123};
        ms = '{ier_pkg::IER_MODE_STARTUP, ier_pkg::IER_MODE_RESTART,
               ier_pkg::IER_MODE_FLASH, ier_pkg::IER_MODE_SLEEP};
        for (int i = 0; i < 4; i++)
            frame(ws[i], 16, 12'h0e3, 16'h40e3);
        for (int i = 0; i < 4; i++)
        begin
            mode <= ms[i];
            frame(16'h4123, 16, 12'h0e3, 16'h40e3);
        end
        mode <= ier_pkg::IER_MODE_NORMAL;
        frame(16'h4123, 15, 12'h0e3, 16'h0000);
        frame(16'h4123, 17, 12'h0e3, 16'h0000);
        `CHK("silent drop", 16'h0000, seen_irq | {15'h0000, seen_rst})
        mode <= ier_pkg::IER_MODE_STANDBY;
        frame(16'h4fff, 16, 12'hffb, 16'h40e3);
        $display("refused write test done");
    endtask

    task automatic t_badcount();
        mode <= ier_pkg::IER_MODE_NORMAL;
        frame(16'h4000, 17, 12'hffb, 16'h0000);
        `CHK("count irq", 17'h00200, {seen_irq, seen_rst})
        mode <= ier_pkg::IER_MODE_STARTUP;
        frame(16'h4000, 15, 12'hffb, 16'h0000);
        `CHK("count reset", 17'h00001, {seen_irq, seen_rst})
        mode <= ier_pkg::IER_MODE_RESTART;
        frame(16'h4000, 17, 12'hffb, 16'h0000);
        `CHK("count reset", 17'h00001, {seen_irq, seen_rst})
        $display("clock count test done");
    endtask

    task automatic t_events();
        logic [7:0] evs [7];
        logic [15:0] irqs [7];
        evs = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
        irqs = '{16'h0400, 16'h0200, 16'h0040, 16'h0020, 16'h0010, 16'h0002, 16'h0001};
        mode <= ier_pkg::IER_MODE_STANDBY;
        for (int i = 0; i < 7; i++)
            ev_case(evs[i], 1'b0, 1'b0, irqs[i], 1'b0);
        ev_case(8'h00, 1'b1, 1'b0, 16'h0080, 1'b0);
        ev_case(8'h00, 1'b0, 1'b1, 16'h0008, 1'b0);
        ev_case(8'h80, 1'b0, 1'b0, 16'h0800, 1'b0);
        `CHK("watchdog enable", 12'h7fb, en)
        ev_case(8'h80, 1'b0, 1'b0, 16'h0000, 1'b1);
        frame(16'h4000, 16, 12'h000, 16'h47fb);
        for (int i = 0; i < 7; i++)
            ev_case(evs[i], 1'b0, 1'b0, 16'h0000, i > 4);
        ev_case(8'h00, 1'b1, 1'b0, 16'h0000, 1'b0);
        ev_case(8'h00, 1'b0, 1'b1, 16'h0000, 1'b1);
        mode <= ier_pkg::IER_MODE_NORMAL;
        ev_case(8'h00, 1'b0, 1'b1, 16'h0000, 1'b0);
        frame(16'h4008, 16, 12'h008, 16'h4000);
        mode <= ier_pkg::IER_MODE_FLASH;
        ev_case(8'h00, 1'b0, 1'b1, 16'h0008, 1'b0);
        $display("event routing test done");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        rst_n_i = 1'b0;
        bat = 1'b1;
        wake = 1'b1;
        mode = ier_pkg::IER_MODE_NORMAL;
        ev = 8'h00;
        seen_clr = 1'b0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        `CHK("reset enables", 12'h000, en)
        t_rw();
        t_refused();
        t_badcount();
        t_events();
        stop_test();
    end
endmodule
